// File: rtl/tsl_map.svh
// constants for the task switch linkage block
`ifndef TSL_MAP_SVH
`define TSL_MAP_SVH
`define TSL_ADDR_CTRL      4'h0
`define TSL_ADDR_STATUS    4'h1
`define TSL_ADDR_INT_STAT  4'h2
`define TSL_ADDR_INT_MASK  4'h3
`define TSL_ADDR_CUR_SEL   4'h4
`define TSL_ADDR_FAULT     4'h5
`define TSL_ADDR_PDB       4'h6
`define TSL_ADDR_LOCAL_SEL 4'h7
`define TSL_CTRL_NEST_BIT  0
`define TSL_CTRL_SWITCHED_BIT 1
`define TSL_INT_DONE_BIT   0
`define TSL_INT_FAULT_BIT  1
`define TSL_VEC_ABSENT     8'h0b
`define TSL_VEC_STACK      8'h0c
`define TSL_VEC_PROT       8'h0d
`define TSL_VEC_STATE      8'h0a
`define TSL_BUSY_BIT       9
`endif

// File: rtl/tsl_pkg.sv
// types for the task switch linkage block
package tsl_pkg;
  typedef enum logic [1:0] {
    TSL_SRC_JUMP = 2'b00,
    TSL_SRC_CALL = 2'b01,
    TSL_SRC_INTR = 2'b11,
    TSL_SRC_RETURN = 2'b10
  } tsl_src_t;
  typedef enum logic [3:0] {
    TSL_IDLE     = 4'b0000,
    TSL_RD_NEW   = 4'b0001,
    TSL_WR_NEW   = 4'b0011,
    TSL_RD_OLD   = 4'b0010,
    TSL_WR_OLD   = 4'b0110,
    TSL_WR_LINK  = 4'b0111,
    TSL_RD_STATE = 4'b0101,
    TSL_DONE     = 4'b0100,
    TSL_FAULT    = 4'b1100
  } tsl_state_t;
  typedef enum logic [1:0] {
    TSL_TBL_GLOBAL = 2'b00,
    TSL_TBL_LOCAL  = 2'b01
  } tsl_tbl_t;
endpackage

// File: rtl/tsl_switch.sv
// task switch linkage controller: busy flags, nesting flag, back link, locking
`timescale 1ns/1ps
`include "tsl_map.svh"
module tsl_switch (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic             sw_req,
  input  wire tsl_pkg::tsl_src_t sw_src,
  input  wire logic [15:0]      sw_sel,
  input  wire logic [15:0]      table_limit,
  input  wire logic             new_desc_present,
  input  wire logic             new_limit_ok,
  input  wire logic             stack_present,
  input  wire logic             state_ok,
  output logic                  mem_req,
  output logic                  mem_we,
  output logic      [15:0]      mem_sel,
  output logic      [1:0]       mem_kind,
  output logic      [31:0]      mem_wdata,
  input  wire logic [31:0]      mem_rdata,
  input  wire logic             mem_ack,
  output logic                  bus_lock,
  output logic                  switch_done,
  output logic                  fault_valid,
  output logic      [7:0]       fault_vector,
  output logic      [15:0]      fault_code,
  output logic                  irq
);
  // mem_kind: 0 descriptor word, 1 back link, 2 page base, 3 local table selector
  tsl_pkg::tsl_state_t state;
  tsl_pkg::tsl_state_t next_state;
  tsl_pkg::tsl_src_t   src;
  logic [15:0] cur_sel;
  logic [15:0] tgt_sel;
  logic [15:0] link_sel;
  logic        nested_task_flag;
  logic        task_switched_flag;
  logic [31:0] desc_word;
  logic [31:0] page_directory_base_reg;
  logic [15:0] local_sel;
  logic [1:0]  int_stat;
  logic [1:0]  int_mask;
  logic [7:0]  last_vec;
  logic [1:0]  load_step;

  function automatic logic sel_valid(input logic [15:0] s, input logic [15:0] lim);
    sel_valid = (s[2] == 1'b0) && ({s[15:3], 3'h7} <= lim);
  endfunction

  wire logic is_ret     = (sw_src == tsl_pkg::TSL_SRC_RETURN);
  wire logic start      = sw_req && (state == tsl_pkg::TSL_IDLE)
                          && (!is_ret || nested_task_flag);
  wire logic [15:0] start_sel = is_ret ? link_sel : sw_sel;
  wire logic links      = (src == tsl_pkg::TSL_SRC_CALL) || (src == tsl_pkg::TSL_SRC_INTR);
  wire logic new_busy   = mem_rdata[`TSL_BUSY_BIT];
  wire logic busy_bad   = (src == tsl_pkg::TSL_SRC_RETURN) ? !new_busy : new_busy;
  wire logic chk_ok     = sel_valid(tgt_sel, table_limit) && new_desc_present && new_limit_ok
                          && !busy_bad;
  wire logic rd_done    = (state == tsl_pkg::TSL_RD_NEW) && mem_ack;
  wire logic [7:0] chk_vec =
      !sel_valid(tgt_sel, table_limit) ? `TSL_VEC_PROT :
      !new_desc_present ? `TSL_VEC_ABSENT :
      busy_bad ? ((src == tsl_pkg::TSL_SRC_RETURN) ? `TSL_VEC_STATE : `TSL_VEC_PROT) :
      `TSL_VEC_STATE;
  wire logic late_fault = (state == tsl_pkg::TSL_DONE) && (!stack_present || !state_ok);
  wire logic [7:0] late_vec = !stack_present ? `TSL_VEC_STACK : `TSL_VEC_STATE;
  wire logic hw_done    = (state == tsl_pkg::TSL_DONE);
  wire logic hw_fault   = (state == tsl_pkg::TSL_FAULT);
  // back link read last, so a call sees the link it has just written
  wire logic last_step  = (state == tsl_pkg::TSL_RD_STATE) && mem_ack && (load_step == 2'h2);

  always_comb
  begin
    next_state = state;
    case (state)
      tsl_pkg::TSL_IDLE:     if (start) next_state = tsl_pkg::TSL_RD_NEW;
      tsl_pkg::TSL_RD_NEW:   if (mem_ack) next_state = chk_ok ?
          ((src == tsl_pkg::TSL_SRC_RETURN) ? tsl_pkg::TSL_RD_OLD : tsl_pkg::TSL_WR_NEW)
          : tsl_pkg::TSL_FAULT;
      tsl_pkg::TSL_WR_NEW:   if (mem_ack) next_state = links ?
          tsl_pkg::TSL_WR_LINK : tsl_pkg::TSL_RD_OLD;
      tsl_pkg::TSL_WR_LINK:  if (mem_ack) next_state = tsl_pkg::TSL_RD_STATE;
      tsl_pkg::TSL_RD_OLD:   if (mem_ack) next_state = tsl_pkg::TSL_WR_OLD;
      tsl_pkg::TSL_WR_OLD:   if (mem_ack) next_state = tsl_pkg::TSL_RD_STATE;
      tsl_pkg::TSL_RD_STATE: if (last_step) next_state = tsl_pkg::TSL_DONE;
      tsl_pkg::TSL_DONE:     next_state = tsl_pkg::TSL_IDLE;
      tsl_pkg::TSL_FAULT:    next_state = tsl_pkg::TSL_IDLE;
      default:               next_state = tsl_pkg::TSL_IDLE;
    endcase
  end

  // descriptor writes are read-modify-write under one lock
  assign mem_req  = (state != tsl_pkg::TSL_IDLE) && (state != tsl_pkg::TSL_DONE)
                    && (state != tsl_pkg::TSL_FAULT);
  assign mem_we   = (state == tsl_pkg::TSL_WR_NEW) || (state == tsl_pkg::TSL_WR_OLD)
                    || (state == tsl_pkg::TSL_WR_LINK);
  assign mem_sel  = ((state == tsl_pkg::TSL_RD_OLD) || (state == tsl_pkg::TSL_WR_OLD))
                    ? cur_sel : tgt_sel;
  assign mem_kind = (state == tsl_pkg::TSL_WR_LINK) ? 2'h1 :
                    (state != tsl_pkg::TSL_RD_STATE) ? 2'h0 :
                    (load_step == 2'h0) ? 2'h2 : (load_step == 2'h1) ? 2'h3 : 2'h1;
  assign mem_wdata = (state == tsl_pkg::TSL_WR_LINK) ? {16'h0000, cur_sel} :
                     (state == tsl_pkg::TSL_WR_NEW) ? (desc_word | 32'h0000_0200) :
                     (desc_word & ~32'h0000_0200);
  assign bus_lock = (state == tsl_pkg::TSL_RD_NEW) || (state == tsl_pkg::TSL_WR_NEW)
                    || (state == tsl_pkg::TSL_RD_OLD) || (state == tsl_pkg::TSL_WR_OLD);
  assign switch_done = hw_done && !late_fault;
  assign irq = |(int_stat & int_mask);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= tsl_pkg::TSL_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src       <= tsl_pkg::TSL_SRC_JUMP;
      tgt_sel   <= 16'h0000;
      desc_word <= 32'h0000_0000;
      load_step <= 2'h0;
    end
    else
    begin
      if (start)
      begin
        src     <= sw_src;
        tgt_sel <= start_sel;
      end
      if (mem_ack && ((state == tsl_pkg::TSL_RD_NEW) || (state == tsl_pkg::TSL_RD_OLD)))
        desc_word <= mem_rdata;
      if (state == tsl_pkg::TSL_RD_STATE && mem_ack)
        load_step <= (load_step == 2'h2) ? 2'h0 : load_step + 2'h1;
    end
  end

  // task context owned by the controller
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_sel                 <= 16'h0000;
      link_sel                <= 16'h0000;
      nested_task_flag        <= 1'b0;
      task_switched_flag      <= 1'b0;
      page_directory_base_reg <= 32'h0000_0000;
      local_sel               <= 16'h0000;
    end
    else
    begin
      if (reg_wr && reg_addr == `TSL_ADDR_CTRL)
      begin
        nested_task_flag   <= reg_wdata[`TSL_CTRL_NEST_BIT];
        task_switched_flag <= reg_wdata[`TSL_CTRL_SWITCHED_BIT];
      end
      if (state == tsl_pkg::TSL_RD_STATE && mem_ack && load_step == 2'h0)
        page_directory_base_reg <= mem_rdata;
      if (state == tsl_pkg::TSL_RD_STATE && mem_ack && load_step == 2'h1)
        local_sel <= mem_rdata[15:0];
      if (last_step)
      begin
        cur_sel            <= tgt_sel;
        link_sel           <= mem_rdata[15:0];
        task_switched_flag <= 1'b1;
        if (links)
          nested_task_flag <= 1'b1;
        else if (src == tsl_pkg::TSL_SRC_RETURN)
          nested_task_flag <= 1'b0;
      end
    end
  end

  // fault report and sticky status, set beats a read clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_valid  <= 1'b0;
      fault_vector <= 8'h00;
      fault_code   <= 16'h0000;
      last_vec     <= 8'h00;
      int_stat     <= 2'h0;
      int_mask     <= 2'h0;
    end
    else
    begin
      fault_valid <= (rd_done && !chk_ok) || late_fault;
      if (rd_done && !chk_ok)
      begin
        fault_vector <= chk_vec;
        fault_code   <= {tgt_sel[15:3], 3'h0};
        last_vec     <= chk_vec;
      end
      else if (late_fault)
      begin
        fault_vector <= late_vec;
        fault_code   <= {tgt_sel[15:3], 3'h0};
        last_vec     <= late_vec;
      end
      if (reg_wr && reg_addr == `TSL_ADDR_INT_MASK)
        int_mask <= reg_wdata[1:0];
      int_stat <= ((reg_rd && reg_addr == `TSL_ADDR_INT_STAT) ? 2'h0 : int_stat)
                  | {hw_fault || late_fault, switch_done};
    end
  end

  wire logic [31:0] rd_mux =
      (reg_addr == `TSL_ADDR_CTRL)     ? {30'h0, task_switched_flag, nested_task_flag} :
      (reg_addr == `TSL_ADDR_STATUS)   ? {28'h0, state} :
      (reg_addr == `TSL_ADDR_INT_STAT) ? {30'h0, int_stat} :
      (reg_addr == `TSL_ADDR_INT_MASK) ? {30'h0, int_mask} :
      (reg_addr == `TSL_ADDR_CUR_SEL)  ? {link_sel, cur_sel} :
      (reg_addr == `TSL_ADDR_FAULT)    ? {8'h0, last_vec, fault_code} :
      (reg_addr == `TSL_ADDR_PDB)      ? page_directory_base_reg :
      (reg_addr == `TSL_ADDR_LOCAL_SEL) ? {16'h0, local_sel} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  sequence s_call_switch;
    start && (sw_src == tsl_pkg::TSL_SRC_CALL);
  endsequence

  a_lock_on_write: assert property (@(posedge clk) disable iff (!rst_n)
    mem_we && mem_kind == 2'h0 |-> bus_lock)
    else $error("descriptor write without bus lock");
  a_busy_fault_gp: assert property (@(posedge clk) disable iff (!rst_n)
    rd_done && src != tsl_pkg::TSL_SRC_RETURN && new_busy && new_desc_present
    |=> fault_valid && fault_vector == `TSL_VEC_PROT)
    else $error("busy target did not fault");
  a_interrupt_return_instr_needs_nt: assert property (@(posedge clk) disable iff (!rst_n)
    state == tsl_pkg::TSL_IDLE && sw_req && is_ret && !nested_task_flag |=>
    state == tsl_pkg::TSL_IDLE)
    else $error("return switch without nesting flag");
  a_ts_after_done: assert property (@(posedge clk) disable iff (!rst_n)
    hw_done |-> task_switched_flag)
    else $error("task switched flag not set");
  a_set_new_busy: assert property (@(posedge clk) disable iff (!rst_n)
    state == tsl_pkg::TSL_WR_NEW |-> mem_wdata[9])
    else $error("new busy flag not set");
  a_clear_old_busy: assert property (@(posedge clk) disable iff (!rst_n)
    state == tsl_pkg::TSL_WR_OLD |-> !mem_wdata[9] && !links)
    else $error("old busy flag not cleared");
  a_call_nests: assert property (@(posedge clk) disable iff (!rst_n)
    last_step && links |=> nested_task_flag && link_sel == $past(cur_sel))
    else $error("call did not nest");
  a_interrupt_return_instr_clears_nt: assert property (@(posedge clk) disable iff (!rst_n)
    hw_done && src == tsl_pkg::TSL_SRC_RETURN |-> !nested_task_flag)
    else $error("return did not clear nesting flag");
  a_call_reads_new: assert property (@(posedge clk) disable iff (!rst_n)
    s_call_switch |=> state == tsl_pkg::TSL_RD_NEW ##0 bus_lock)
    else $error("call switch did not start");
endmodule

// File: verif/tsl_mem_model.sv
// memory model: descriptor words, back links and state block fields
`timescale 1ns/1ps
module tsl_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_sel,
  input  wire logic [1:0]  mem_kind,
  input  wire logic [31:0] mem_wdata,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [31:0] desc [32]; // one fixed region seen alike by every task
  logic [15:0] link [32];
  logic [1:0]  wait_cnt;
  wire  [4:0]  idx = mem_sel[7:3];
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_cnt = 2'h0;
    for (int i = 0; i < 32; i++)
    begin
      desc[i] = (i == 0) ? 32'h0000_0289 : 32'h0000_0089;
      link[i] = 16'h0008; // no link left pointing at an unknown task
    end
  end
  always @(posedge clk)
  begin
    if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h3))
    begin
      mem_ack <= 1'b1;
      wait_cnt <= 2'h0;
      if (mem_we && mem_kind == 2'h0)
        desc[idx] <= mem_wdata;
      if (mem_we && mem_kind == 2'h1)
        link[idx] <= mem_wdata[15:0];
      mem_rdata <= (mem_kind == 2'h0) ? desc[idx] :
                   (mem_kind == 2'h2) ? {16'h5a00, mem_sel} :
                   (mem_kind == 2'h1) ? {16'h0, link[idx]} : {16'h0, ~mem_sel};
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // stale data must not look valid
      wait_cnt <= mem_req ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the task switch linkage controller
`timescale 1ns/1ps
`include "tsl_map.svh"
module tb_top;
  typedef struct packed {
    tsl_pkg::tsl_src_t src;
    logic [15:0]       sel;
    logic [3:0]        ok; // present, limit, stack, state
    logic              slow;
    logic [7:0]        vec; // 0 when the switch completes
  } tsl_row_t;
  localparam tsl_pkg::tsl_src_t J = tsl_pkg::TSL_SRC_JUMP;
  localparam tsl_pkg::tsl_src_t C = tsl_pkg::TSL_SRC_CALL;
  localparam tsl_pkg::tsl_src_t I = tsl_pkg::TSL_SRC_INTR;
  localparam tsl_pkg::tsl_src_t R = tsl_pkg::TSL_SRC_RETURN;
  logic              clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sw_req = 0, slow = 0;
  logic [3:0]        reg_addr = 4'h0, ok = 4'hf;
  logic [31:0]       reg_wdata = 32'h0, reg_rdata, mem_wdata, mem_rdata;
  logic [15:0]       sw_sel = 16'h0, mem_sel, fault_code, cur = 16'h0, tgt;
  logic [1:0]        mem_kind;
  logic [7:0]        fault_vector;
  logic              mem_req, mem_we, mem_ack, bus_lock, switch_done, fault_valid, irq;
  logic              nest_ref = 1'b0;
  tsl_pkg::tsl_src_t sw_src = J;
  logic              busy_ref [32];
  logic [15:0]       link_ref [32];
  int                err_count = 0, n_compared = 0;
  tsl_row_t          rows [12] = '{'{J, 16'h08, 4'hf, 1'b0, 8'h00}, '{C, 16'h10, 4'hf, 1'b1, 8'h00},
    '{C, 16'h08, 4'hf, 1'b0, 8'h0d}, '{I, 16'h18, 4'hf, 1'b1, 8'h00},
    '{R, 16'h00, 4'hf, 1'b0, 8'h00}, '{J, 16'h24, 4'hf, 1'b0, 8'h0d},
    '{J, 16'h80, 4'hf, 1'b0, 8'h0d}, '{J, 16'h78, 4'h7, 1'b0, 8'h0b},
    '{J, 16'h78, 4'hb, 1'b0, 8'h0a}, '{J, 16'h78, 4'hf, 1'b1, 8'h00},
    '{C, 16'h20, 4'hd, 1'b0, 8'h0c}, '{J, 16'h30, 4'he, 1'b0, 8'h0a}};
  always #12.5 clk = ~clk;
  tsl_switch dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_req(sw_req), .sw_src(sw_src),
    .sw_sel(sw_sel), .table_limit(16'h007f), .new_desc_present(ok[3]), .new_limit_ok(ok[2]),
    .stack_present(ok[1]), .state_ok(ok[0]), .mem_req(mem_req), .mem_we(mem_we),
    .mem_sel(mem_sel), .mem_kind(mem_kind), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .bus_lock(bus_lock), .switch_done(switch_done),
    .fault_valid(fault_valid), .fault_vector(fault_vector), .fault_code(fault_code), .irq(irq));
  tsl_mem_model mem_u (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_sel(mem_sel), .mem_kind(mem_kind), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic run(input tsl_row_t r);
    logic [15:0] old;
    logic        late;
    old = cur;
    tgt = (r.src == R) ? link_ref[cur[7:3]] : r.sel;
    late = r.vec != 8'h0 && r.ok[1:0] != 2'b11;
    @(posedge clk);
    sw_src <= r.src;
    sw_sel <= r.sel;
    ok <= r.ok;
    slow <= r.slow;
    sw_req <= 1'b1;
    @(posedge clk);
    sw_req <= 1'b0;
    #1;
    for (int i = 0; i < 400 && switch_done !== 1'b1 && fault_valid !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("done", {31'h0, r.vec == 8'h0}, {31'h0, switch_done});
    chk("vector", {24'h0, r.vec}, fault_valid ? {24'h0, fault_vector} : 32'h0);
    if (r.vec != 8'h0)
      chk("code", {16'h0, tgt[15:3], 3'h0}, {16'h0, fault_code});
    if (r.vec == 8'h0 || late)
    begin
      // src bit 0 marks call and interrupt, which nest
      busy_ref[tgt[7:3]] = busy_ref[tgt[7:3]] | (r.src != R);
      busy_ref[old[7:3]] = busy_ref[old[7:3]] & r.src[0];
      link_ref[tgt[7:3]] = r.src[0] ? old : link_ref[tgt[7:3]];
      nest_ref = r.src[0] | (nest_ref & (r.src == J));
      cur = tgt;
    end
    chk("busy new", {31'h0, busy_ref[tgt[7:3]]}, {31'h0, mem_u.desc[tgt[7:3]][9]});
    chk("busy old", {31'h0, busy_ref[old[7:3]]}, {31'h0, mem_u.desc[old[7:3]][9]});
    chk("link new", {16'h0, link_ref[tgt[7:3]]}, {16'h0, mem_u.link[tgt[7:3]]});
    chk("link old", {16'h0, link_ref[old[7:3]]}, {16'h0, mem_u.link[old[7:3]]});
    if (r.vec == 8'h0 || late)
    begin
      rd_chk("page base", `TSL_ADDR_PDB, {16'h5a00, cur});
      rd_chk("local table", `TSL_ADDR_LOCAL_SEL, {16'h0, ~cur});
      rd_chk("current", `TSL_ADDR_CUR_SEL, {link_ref[cur[7:3]], cur});
      rd_chk("ctrl", `TSL_ADDR_CTRL, {30'h0, 1'b1, nest_ref});
    end
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
    if (mem_req === 1'b1 && mem_kind === 2'h0)
      chk("lock", 32'h1, {31'h0, bus_lock});
  initial
  begin
    #(25 * 20000);
    err_count++;
    final_report;
  end
  initial
  begin
    for (int i = 0; i < 32; i++)
    begin
      busy_ref[i] = (i == 0);
      link_ref[i] = 16'h0008;
    end
    repeat (8) @(posedge clk);
    chk("reset outs", 32'h0, {29'h0, irq, fault_valid, mem_req});
    rst_n <= 1'b1;
    rd_chk("current", `TSL_ADDR_CUR_SEL, 32'h0);
    wr(`TSL_ADDR_INT_MASK, 32'h3);
    foreach (rows[i])
      run(rows[i]);
    wr(`TSL_ADDR_INT_MASK, 32'h0);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    wr(`TSL_ADDR_INT_MASK, 32'h3);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd_chk("status", `TSL_ADDR_INT_STAT, 32'h3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(`TSL_ADDR_CTRL, 32'h2);
    @(posedge clk);
    sw_src <= R;
    sw_req <= 1'b1;
    @(posedge clk);
    sw_req <= 1'b0;
    repeat (40) @(posedge clk);
    rd_chk("return unnested", `TSL_ADDR_INT_STAT, 32'h0);
    wr(`TSL_ADDR_CTRL, 32'h3);
    nest_ref = 1'b1;
    run('{R, 16'h0, 4'hf, 1'b0, 8'h00});
    rd_chk("unmapped", 4'hf, 32'h0);
    final_report;
  end
endmodule
